// File: src/sync_burst_sram_port.sv
// synchronous flow-through burst sram, device side
// assumes all inputs synchronous to core_clk; pads resolved outside
`timescale 1ns/100ps
// Notes on behaviour
// - processor strobe low loads address register and burst counter low bits.
// - controller strobe low loads address register and burst counter low bits.
// - both strobes low: the processor strobe counts, or the controller strobe while first chip select is high.
// - processor strobe ignored while first chip select is high.
// - sleep request high enters retention sleep; low for normal operation.
// - an undriven sleep request reads as low.
// - write data is written straight into the array on the clock edge.
// - read data comes from location addressed at the previous edge.
// - output gate low drives data and parity; high floats them.
// - float during write data phase, first cycle after deselect, deselected.
// - parity lanes act as data; written per matching byte lane select.
// - strap low selects linear order; high or open selects interleaved.
// - burst advance low steps the counter in the selected order.
// - counter wraps within four; interleaved flips bits, linear counts up.
// - all-bytes write low writes every lane, ignoring gate and selects.
// - chip selects sampled only when a new address is loaded.
module sync_burst_sram_port #(
   parameter int ADDR_W = burst_sram_pkg::ADDR_W,
   parameter int LANES = burst_sram_pkg::LANES,
   parameter int LANE_W = burst_sram_pkg::LANE_W
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic processor_addr_strobe_n,
   input wire logic controller_addr_strobe_n,
   input wire logic burst_advance_n,
   input wire logic first_chip_select_n,
   input wire logic second_chip_select,
   input wire logic third_chip_select_n,
   input wire logic byte_write_gate_n,
   input wire logic [LANES-1:0] byte_lane_select_n,
   input wire logic all_bytes_write_n,
   input wire logic output_gate_n,
   input wire logic sleep_request,
   input wire logic sleep_request_driven,
   input wire logic burst_order,
   input wire logic [LANES*LANE_W-1:0] data_in,
   output logic [LANES*LANE_W-1:0] data_out,
   output logic data_oe_n,
   input wire logic [LANES-1:0] parity_lines_in,
   output logic [LANES-1:0] parity_lines_out,
   output logic parity_lines_oe_n,
   output logic asleep
);
   localparam int WORD_W = LANES * (LANE_W + 1);
   typedef burst_sram_pkg::cycle_state_t cycle_state_t;

   // ==========================================================
   // helpers
   function automatic logic [WORD_W-1:0] pack_word(
      input logic [LANES*LANE_W-1:0] d,
      input logic [LANES-1:0] p
   );
      logic [WORD_W-1:0] w;
      w = '0;
      for (int i = 0; i < LANES; i++) begin
         w[i*(LANE_W+1) +: (LANE_W+1)] = {p[i], d[i*LANE_W +: LANE_W]};
      end
      return w;
   endfunction

   // ==========================================================
   // sleep request: undriven reads low, two-flop sync
   logic sleep_level;
   logic [1:0] sleep_sync_q;
   logic [1:0] sleep_sync_d;
   assign sleep_level = sleep_request & sleep_request_driven;

   always_comb begin
      sleep_sync_d = {sleep_sync_q[0], sleep_level};
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         sleep_sync_q <= burst_sram_pkg::SLEEP_SYNC_RESET;
      end else begin
         sleep_sync_q <= sleep_sync_d;
      end
   end

   logic sleeping;
   assign sleeping = sleep_sync_q[1];

   // ==========================================================
   // address and burst control
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [1:0] start_q, start_d;
   logic [1:0] count_q, count_d;
   logic order_q, order_d;
   logic selected_q, selected_d;
   cycle_state_t state_q, state_d;
   logic first_after_desel_q, first_after_desel_d;
   logic [1:0] step_next;

   logic proc_take, ctrl_take, load, chips_on, write_now, write_lanes_any;
   logic [LANES-1:0] lane_we;

   // strap pulled high outside when left open; sampled every cycle, static
   burst_step u_step (
      .start(start_q),
      .count(count_q),
      .order(order_q),
      .next_count(step_next)
   );

   always_comb begin
      proc_take = ~processor_addr_strobe_n & ~first_chip_select_n;
      ctrl_take = ~controller_addr_strobe_n & ~proc_take;
      load = (proc_take | ctrl_take) & ~sleeping;
      chips_on = ~first_chip_select_n & second_chip_select & ~third_chip_select_n;
      // all-bytes write overrides; gated byte lanes
      if (~all_bytes_write_n) begin
         lane_we = '1;
      end else if (~byte_write_gate_n) begin
         lane_we = ~byte_lane_select_n;
      end else begin
         lane_we = '0;
      end
      write_lanes_any = |lane_we;
      // processor-started cycle ignores write inputs in its first clock
      write_now = write_lanes_any & ~proc_take & ~sleeping;
   end

   always_comb begin
      addr_d = addr_q;
      start_d = start_q;
      count_d = count_q;
      order_d = burst_order;
      selected_d = selected_q;
      state_d = state_q;
      first_after_desel_d = 1'b0;
      if (load) begin
         addr_d = addr;
         start_d = addr[1:0];
         count_d = addr[1:0];
         selected_d = chips_on;
         first_after_desel_d = ~selected_q & chips_on;
      end else if (~burst_advance_n & selected_q & ~sleeping) begin
         count_d = step_next;
      end else begin
         count_d = count_q;
      end
      case (state_q)
         burst_sram_pkg::st_deselected,
         burst_sram_pkg::st_read,
         burst_sram_pkg::st_write: begin
            if (sleeping | ~selected_d) begin
               state_d = burst_sram_pkg::st_deselected;
            end else if (write_now) begin
               state_d = burst_sram_pkg::st_write;
            end else begin
               state_d = burst_sram_pkg::st_read;
            end
         end
         default: state_d = burst_sram_pkg::st_deselected;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         addr_q <= '0;
         start_q <= burst_sram_pkg::BURST_RESET;
         count_q <= burst_sram_pkg::BURST_RESET;
         order_q <= burst_sram_pkg::ORDER_INTERLEAVED;
         selected_q <= 1'b0;
         state_q <= burst_sram_pkg::st_deselected;
         first_after_desel_q <= 1'b0;
      end else begin
         addr_q <= addr_d;
         start_q <= start_d;
         count_q <= count_d;
         order_q <= order_d;
         selected_q <= selected_d;
         state_q <= state_d;
         first_after_desel_q <= first_after_desel_d;
      end
   end

   // ==========================================================
   // memory access: write uses the address of this cycle
   logic [ADDR_W-1:0] cur_addr;
   logic [WORD_W-1:0] rd_word, wr_word;
   logic [LANES-1:0] core_we;

   always_comb begin
      cur_addr = load ? addr : {addr_q[ADDR_W-1:2], count_d};
      wr_word = pack_word(data_in, parity_lines_in);
      // writes land in the cycle after the address is registered
      if (write_now & selected_q & ~load) begin
         core_we = lane_we;
      end else begin
         core_we = '0;
      end
   end

   burst_sram_core #(
      .ADDR_W(ADDR_W),
      .LANES(LANES),
      .LANE_W(LANE_W + 1)
   ) u_core (
      .core_clk(core_clk),
      .rd_addr(cur_addr),
      .rd_data(rd_word),
      .wr_addr({addr_q[ADDR_W-1:2], count_q}),
      .wr_lane_en(core_we),
      .wr_data(wr_word)
   );

   // ==========================================================
   // output drive
   logic [LANES*LANE_W-1:0] data_out_q, data_out_d;
   logic [LANES-1:0] par_out_q, par_out_d;
   logic oe_n_q, oe_n_d, asleep_q;
   logic float_now;

   always_comb begin
      for (int i = 0; i < LANES; i++) begin
         data_out_d[i*LANE_W +: LANE_W] = rd_word[i*(LANE_W+1) +: LANE_W];
         par_out_d[i] = rd_word[i*(LANE_W+1) + LANE_W];
      end
      // outputs stay off in write, first cycle after deselect, and deselect
      float_now = (state_d != burst_sram_pkg::st_read) | first_after_desel_d;
      oe_n_d = output_gate_n | float_now;
   end

   // data word is the core register; gate sampled each clock, so one cycle late
   always_ff @(posedge core_clk) begin
      if (reset) begin
         oe_n_q <= 1'b1;
         asleep_q <= 1'b0;
      end else begin
         oe_n_q <= oe_n_d;
         asleep_q <= sleeping;
      end
   end

   always_comb begin
      data_out = data_out_d;
      parity_lines_out = par_out_d;
   end

   assign data_oe_n = oe_n_q;
   assign parity_lines_oe_n = oe_n_q;
   assign asleep = asleep_q;
endmodule // sync_burst_sram_port

// File: inc/burst_sram_pkg.sv
// constants shared by the burst sram port design
// assumes a single 125 MHz core clock domain
package burst_sram_pkg;
   // ==========================================================
   // geometry
   localparam int ADDR_W = 19;
   localparam int LANES = 4;
   localparam int LANE_W = 8;
   localparam int BURST_W = 2;
   // ==========================================================
   // reset values
   localparam logic [BURST_W-1:0] BURST_RESET = 2'h0;
   localparam logic [1:0] SLEEP_SYNC_RESET = 2'h0;
   // ==========================================================
   // burst order strap levels
   localparam logic ORDER_LINEAR = 1'b0;
   localparam logic ORDER_INTERLEAVED = 1'b1;
   // ==========================================================
   // cycle states of the port
   typedef enum logic [1:0] {
      st_deselected,
      st_read,
      st_write
   } cycle_state_t;
endpackage

// File: src/burst_sram_core.sv
// memory array with registered read data and per-lane write
// assumes writes and reads use the same clock
`timescale 1ns/100ps
module burst_sram_core #(
   parameter int ADDR_W = 19,
   parameter int LANES = 4,
   parameter int LANE_W = 9
) (
   input wire logic core_clk,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [LANES*LANE_W-1:0] rd_data,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [LANES-1:0] wr_lane_en,
   input wire logic [LANES*LANE_W-1:0] wr_data
);
   logic [LANES*LANE_W-1:0] mem_q [0:(1<<ADDR_W)-1];
   logic [LANES*LANE_W-1:0] rd_data_q;

   always_ff @(posedge core_clk) begin
      for (int i = 0; i < LANES; i++) begin
         if (wr_lane_en[i]) begin
            mem_q[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
         end
      end
      rd_data_q <= mem_q[rd_addr];
   end

   assign rd_data = rd_data_q;
endmodule // burst_sram_core

// File: src/burst_step.sv
// next address of the two-bit burst counter
// assumes the order strap is static while running
`timescale 1ns/100ps
module burst_step (
   input wire logic [1:0] start,
   input wire logic [1:0] count,
   input wire logic order,
   output logic [1:0] next_count
);
   logic [1:0] step_n;

   // interleaved order walks the step index and xors with the start
   always_comb begin
      step_n = (count ^ start) + 2'h1;
      if (order == burst_sram_pkg::ORDER_INTERLEAVED) begin
         next_count = start ^ step_n;
      end else begin
         next_count = count + 2'h1;
      end
   end
endmodule // burst_step

// File: test/port_checker.sv
// pin-level assertions for the burst sram port
// assumes one clock domain; bound to every instance of the port
`timescale 1ns/100ps
module port_checker #(
   parameter int LANES = 4,
   parameter int LANE_W = 8
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic processor_addr_strobe_n,
   input wire logic controller_addr_strobe_n,
   input wire logic burst_advance_n,
   input wire logic first_chip_select_n,
   input wire logic second_chip_select,
   input wire logic byte_write_gate_n,
   input wire logic [LANES-1:0] byte_lane_select_n,
   input wire logic all_bytes_write_n,
   input wire logic output_gate_n,
   input wire logic sleep_request,
   input wire logic sleep_request_driven,
   input wire logic [LANES*LANE_W-1:0] data_out,
   input wire logic data_oe_n,
   input wire logic parity_lines_oe_n,
   input wire logic asleep
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   logic no_ld, quiet, desel_ld, wr, sleepy;
   assign no_ld = processor_addr_strobe_n && controller_addr_strobe_n;
   assign quiet = all_bytes_write_n && byte_write_gate_n && burst_advance_n && controller_addr_strobe_n;
   assign desel_ld = processor_addr_strobe_n && !controller_addr_strobe_n && !second_chip_select;
   assign wr = !all_bytes_write_n || (!byte_write_gate_n && !(&byte_lane_select_n));
   assign sleepy = sleep_request && sleep_request_driven;
   // ========================================
   // checks
   a_gate_floats: assert property (output_gate_n |=> data_oe_n)
      else $error("lines driven with gate high");
   a_parity_follows: assert property (parity_lines_oe_n == data_oe_n)
      else $error("parity enable differs from data enable");
   a_write_floats: assert property (wr && processor_addr_strobe_n |=> data_oe_n)
      else $error("lines driven during write data");
   a_deselect_floats: assert property (desel_ld ##1 no_ld |=> data_oe_n)
      else $error("lines driven while deselected");
   a_sleep_enters: assert property (sleepy [*5] |-> asleep)
      else $error("no sleep on request");
   a_sleep_exits: assert property (!sleepy [*5] |-> !asleep)
      else $error("still asleep");
   a_open_pin_awake: assert property (!sleep_request_driven [*5] |-> !asleep)
      else $error("asleep with open sleep pin");
   a_counter_holds: assert property ((processor_addr_strobe_n && quiet) [*2] |=> $stable(data_out))
      else $error("address moved without advance");
   a_strobe_ignored: assert property ((!processor_addr_strobe_n && first_chip_select_n && quiet)
      ##1 (processor_addr_strobe_n && quiet) |=> $stable(data_out))
      else $error("strobe taken with chip select high");
   c_sleep: cover property (sleepy ##5 asleep);
   c_burst: cover property (!burst_advance_n [*3]);
   c_deselect: cover property (desel_ld);
endmodule // port_checker

bind sync_burst_sram_port port_checker #(.LANES(LANES), .LANE_W(LANE_W)) i_checker (
   .core_clk, .reset, .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n,
   .first_chip_select_n, .second_chip_select, .byte_write_gate_n, .byte_lane_select_n,
   .all_bytes_write_n, .output_gate_n, .sleep_request, .sleep_request_driven, .data_out,
   .data_oe_n, .parity_lines_oe_n, .asleep);

// File: test/master_pad_model.sv
// bus master side of the shared data and parity lines
// assumes the master drives only in write data phases
`timescale 1ns/100ps
module master_pad_model (
   input wire logic core_clk,
   input wire logic master_drive,
   input wire logic [35:0] master_word,
   input wire logic [35:0] device_word,
   input wire logic device_oe_n,
   output logic [35:0] pad_word
);
   logic [35:0] last_q;
   // floating lines change every cycle so a stale value never passes
   always_comb begin
      if (master_drive) begin
         pad_word = master_word;
      end else if (!device_oe_n) begin
         pad_word = device_word;
      end else begin
         pad_word = ~last_q;
      end
   end
   always_ff @(posedge core_clk) begin
      last_q <= pad_word;
   end
endmodule // master_pad_model

// File: test/testbench.sv
// self-checking bench for the burst sram port
// assumes 32 data and 4 parity lines; inputs change at falling edges
`timescale 1ns/100ps
module testbench;
   logic core_clk, reset, processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n;
   logic first_chip_select_n, second_chip_select, third_chip_select_n, byte_write_gate_n;
   logic all_bytes_write_n, output_gate_n, sleep_request, sleep_request_driven, burst_order;
   logic data_oe_n, parity_lines_oe_n, asleep, master_drive;
   logic [3:0] byte_lane_select_n, parity_lines_in, parity_lines_out;
   logic [burst_sram_pkg::ADDR_W-1:0] addr;
   logic [31:0] data_in, data_out;
   logic [35:0] master_word, pad_word, got;
   int n_fail, comparisons;
   sync_burst_sram_port i_dut (.core_clk, .reset, .addr, .processor_addr_strobe_n,
      .controller_addr_strobe_n, .burst_advance_n, .first_chip_select_n, .second_chip_select,
      .third_chip_select_n, .byte_write_gate_n, .byte_lane_select_n, .all_bytes_write_n,
      .output_gate_n, .sleep_request, .sleep_request_driven, .burst_order, .data_in, .data_out,
      .data_oe_n, .parity_lines_in, .parity_lines_out, .parity_lines_oe_n, .asleep);
   master_pad_model i_pad (.core_clk, .master_drive, .master_word,
      .device_word({parity_lines_out, data_out}), .device_oe_n(data_oe_n), .pad_word);
   assign {parity_lines_in, data_in} = pad_word;
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // ========================================
   // helpers
   function automatic logic [35:0] pat(input logic [1:0] i);
      return {2'h2, i, 30'h15a50000, i};
   endfunction
   task automatic tick();
      @(negedge core_clk);
   endtask
   task automatic idle();
      {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h7;
      {byte_write_gate_n, all_bytes_write_n, byte_lane_select_n} = 6'h3f;
      {first_chip_select_n, second_chip_select, third_chip_select_n} = 3'h2;
      master_drive = 1'b0;
   endtask
   task automatic check_word(input logic [35:0] g, input logic [35:0] e);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: word %h, wanted %h", $time, g, e);
      end
   endtask
   task automatic check_bit(input logic g, input logic e);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: flag %b, wanted %b", $time, g, e);
      end
   endtask
   // ctl is {all-bytes write, lane selects}; byte gate is low only for lane writes
   task automatic write_word(input logic [18:0] a, input logic [35:0] w, input logic [4:0] ctl);
      tick();
      addr = a;
      processor_addr_strobe_n = 1'b0;
      tick();
      processor_addr_strobe_n = 1'b1;
      {all_bytes_write_n, byte_lane_select_n} = ctl;
      byte_write_gate_n = ~ctl[4];
      master_word = w;
      master_drive = 1'b1;
      tick();
      idle();
   endtask
   task automatic read_word(input logic [18:0] a);
      tick();
      addr = a;
      controller_addr_strobe_n = 1'b0;
      tick();
      idle();
      tick();
      got = {parity_lines_out, data_out};
   endtask
   // ========================================
   // scenarios
   task automatic fill_scenario();
      for (int i = 0; i < 4; i++) begin
         write_word({17'h00040, 2'(i)}, pat(2'(i)), 5'h0f);
      end
   endtask
   // order changes only under reset, keeping the strap static in operation
   task automatic burst_scenario(input logic order, input logic [1:0] start);
      burst_order = order;
      reset = 1'b1;
      repeat (2) tick();
      reset = 1'b0;
      tick();
      addr = {17'h00040, start};
      controller_addr_strobe_n = 1'b0;
      tick();
      controller_addr_strobe_n = 1'b1;
      burst_advance_n = 1'b0;
      // first word stands right after the load edge, one step per edge after
      for (int i = 0; i < 4; i++) begin
         check_word({parity_lines_out, data_out}, pat(order ? start ^ 2'(i) : start + 2'(i)));
         tick();
      end
      check_bit(data_oe_n, 1'b0);
      check_bit(parity_lines_oe_n, 1'b0);
      idle();
   endtask
   task automatic byte_scenario();
      write_word(19'h00102, 36'h0, 5'h1a);
      read_word(19'h00102);
      check_word(got, pat(2'h2) & 36'haff00ff00);
   endtask
   task automatic strobe_scenario();
      tick();
      addr = 19'h00100;
      {processor_addr_strobe_n, controller_addr_strobe_n, all_bytes_write_n} = 3'h0;
      master_word = 36'h0;
      master_drive = 1'b1;
      tick();
      idle();
      read_word(19'h00100);
      check_word(got, pat(2'h0));
      read_word(19'h00101);
      addr = 19'h00103;
      {processor_addr_strobe_n, first_chip_select_n} = 2'h1;
      tick();
      idle();
      tick();
      check_word({parity_lines_out, data_out}, pat(2'h1));
   endtask
   task automatic float_scenario();
      tick();
      {controller_addr_strobe_n, second_chip_select} = 2'h0;
      tick();
      idle();
      repeat (2) tick();
      check_bit(data_oe_n, 1'b1);
      output_gate_n = 1'b1;
      read_word(19'h00103);
      check_word(got, pat(2'h3));
      tick();
      check_bit(data_oe_n, 1'b1);
      output_gate_n = 1'b0;
      repeat (2) tick();
      check_bit(data_oe_n, 1'b0);
   endtask
   task automatic sleep_scenario();
      {controller_addr_strobe_n, second_chip_select} = 2'h0;
      tick();
      idle();
      sleep_request = 1'b1;
      repeat (6) tick();
      check_bit(asleep, 1'b1);
      sleep_request_driven = 1'b0;
      repeat (6) tick();
      check_bit(asleep, 1'b0);
      {sleep_request, sleep_request_driven} = 2'h1;
      repeat (6) tick();
      check_bit(asleep, 1'b0);
      read_word(19'h00101);
      check_word(got, pat(2'h1));
   endtask
   task automatic print_verdict();
      $display("mismatches %0d, comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // the tests need well under 1000 cycles
   initial begin
      #100000;
      n_fail++;
      print_verdict();
   end
   initial begin
      {n_fail, comparisons, reset, addr, master_word, output_gate_n} = '0;
      {sleep_request, sleep_request_driven, burst_order} = 3'h3;
      reset = 1'b1;
      idle();
      repeat (10) tick();
      reset = 1'b0;
      fill_scenario();
      burst_scenario(burst_sram_pkg::ORDER_INTERLEAVED, 2'h1);
      burst_scenario(burst_sram_pkg::ORDER_LINEAR, 2'h1);
      byte_scenario();
      strobe_scenario();
      float_scenario();
      sleep_scenario();
      print_verdict();
   end
endmodule // testbench
